//--- pkg/lfdc_pkg.sv
// LUT fan duty control package: register map, field layout, reset values,
// timing counts and carrier types. Assumes a 50 MHz system clock.
// Behaviour
// - Twelve temperature/duty pairs form a table that sets fan duty from remote temperature.
// - Output duty is the duty value over the full-duty value of the selected frequency.
// - At the 22.5 kHz fine setting the duty step is 0.392 percent (255 steps).
// - Without smoothing the duty jumps straight to the new entry's value.
// - With smoothing the duty moves one LSB toward the target per interval.
// - Below the first set-point duty is zero; above one, its duty holds until the next.
// - Comparison resolution is 1 or 0.5 degree; at 0.5 the switch point is 0.5 above.
// - On falling temperature held set-points are lowered by the hysteresis amount.
// - An active critical-temperature output forces full duty at once.
// - The step interval is one of 0.182, 0.091, 0.046 or 0.023 seconds.
// - One interval setting governs every table transition.
// - The tach counter counts 90 kHz periods over one two-pulse revolution.
// - The tach count reads as low byte at 0x46 and high byte at 0x47.
package lfdc_pkg;
  // Clock and tick rates
  localparam int CLK_HZ        = 50_000_000;
  localparam int FINE_TICK_HZ  = 5_760_000; // 22.5 kHz times 256 steps
  localparam int FAST_TICK_HZ  = 360_000;
  localparam int SLOW_TICK_HZ  = 1_406;
  localparam int TACH_TICK_HZ  = 90_000;
  localparam int FINE_TICK_CYC = CLK_HZ / FINE_TICK_HZ;
  localparam int FAST_TICK_CYC = CLK_HZ / FAST_TICK_HZ;
  localparam int SLOW_TICK_CYC = CLK_HZ / SLOW_TICK_HZ;
  localparam int TACH_TICK_CYC = CLK_HZ / TACH_TICK_HZ;
  // Smoothing step intervals, in milliseconds
  localparam int STEP_A_MS  = 182;
  localparam int STEP_B_MS  = 91;
  localparam int STEP_C_MS  = 46;
  localparam int STEP_D_MS  = 23;
  localparam int STEP_A_CYC = CLK_HZ / 1000 * STEP_A_MS;
  localparam int STEP_B_CYC = CLK_HZ / 1000 * STEP_B_MS;
  localparam int STEP_C_CYC = CLK_HZ / 1000 * STEP_C_MS;
  localparam int STEP_D_CYC = CLK_HZ / 1000 * STEP_D_MS;
  // Register offsets
  localparam logic [7:0] REG_ENH_CFG  = 8'h45;
  localparam logic [7:0] REG_TACH_LO  = 8'h46;
  localparam logic [7:0] REG_TACH_HI  = 8'h47;
  localparam logic [7:0] REG_PWM_CFG  = 8'h4A;
  localparam logic [7:0] REG_DUTY     = 8'h4C;
  localparam logic [7:0] REG_FREQ     = 8'h4D;
  localparam logic [7:0] REG_HYST     = 8'h4E;
  localparam logic [7:0] REG_SMOOTH   = 8'h4F;
  localparam logic [7:0] REG_LUT_BASE = 8'h50;
  localparam int         LUT_ENTRIES  = 12;
  localparam int         LUT_WORDS    = 24;
  // Field positions
  localparam int FINE_BIT     = 4;
  localparam int CLKSEL_BIT   = 3;
  localparam int SM_EN_BIT    = 0;
  localparam int SM_INT_LSB   = 1;
  localparam int HALF_RES_BIT = 3;
  localparam int LUT_EN_BIT   = 4;
  // Fixed values
  localparam logic [4:0] FINE_FREQ = 5'h08;
  localparam logic [7:0] FULL_FINE = 8'hFF;
  // Reset values
  localparam logic [7:0] RST_MANUAL = 8'h00;
  localparam logic [4:0] RST_FREQ   = 5'h08;
  localparam logic [7:0] RST_HYST   = 8'h02;
  localparam logic [7:0] RST_SMOOTH = 8'h10;

  // Byte-wide register write/select port
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } lfdc_reg_req_t;

  // Software configuration
  typedef struct packed {
    logic       fine;
    logic       clksel;
    logic [4:0] freq;
    logic       sm_en;
    logic [1:0] sm_int;
    logic       half_res;
    logic       lut_en;
    logic [7:0] hyst;
    logic [7:0] manual;
  } lfdc_cfg_t;

  typedef enum logic {SC_TEMP, SC_DUTY} lfdc_scan_t;
endpackage

//--- verilog/lfdc_lut_mem.sv
// Table storage: one write port, one read port with registered data.
// Assumes the caller keeps both addresses below WORDS.
`timescale 1ns/100ps
module lfdc_lut_mem
  import lfdc_pkg::*;
#(
  parameter int WORDS = LUT_WORDS,
  parameter int AW    = 5,
  parameter int DW    = 8
) (
  // Clock and reset
  input  wire logic          ref_clk_in,
  input  wire logic          arst_n_in,
  // Write side
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  // Read side
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out
);
  typedef struct packed {
    logic [WORDS-1:0][DW-1:0] mem;
    logic [DW-1:0]            rdata;
  } lfdc_mem_st_t;

  lfdc_mem_st_t s_reg;
  lfdc_mem_st_t s_next;

  // Read first, read sees old word on a same-address clash
  always_comb begin
    s_next       = s_reg;
    s_next.rdata = s_reg.mem[rd_addr_in];
    if (wr_en_in) begin
      s_next.mem[wr_addr_in] = wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_out = s_reg.rdata;
endmodule // lfdc_lut_mem

//--- verilog/lfdc_tach_counter.sv
// Tach period counter: 90 kHz ticks over one two-pulse revolution.
// Assumes the tach input is already synchronous to the clock.
`timescale 1ns/100ps
module lfdc_tach_counter
  import lfdc_pkg::*;
#(
  parameter int TICK_CYC = TACH_TICK_CYC,
  parameter int CW       = 16
) (
  // Clock and reset
  input  wire logic          ref_clk_in,
  input  wire logic          arst_n_in,
  // Fan tach and result
  input  wire logic          tach_in,
  output logic      [CW-1:0] count_out
);
  typedef struct packed {
    logic [9:0]    div;
    logic          prev;
    logic          armed;
    logic          ph;
    logic [CW-1:0] run;
    logic [CW-1:0] count;
  } lfdc_tach_st_t;

  lfdc_tach_st_t s_reg;
  lfdc_tach_st_t s_next;
  logic          tick;
  logic          rise;

  // Tick divider, edge pairing and saturating count
  always_comb begin
    s_next      = s_reg;
    tick        = (s_reg.div == 10'(TICK_CYC - 1));
    rise        = tach_in & ~s_reg.prev;
    s_next.prev = tach_in;
    s_next.div  = tick ? 10'h000 : s_reg.div + 10'h001;
    if (tick && (s_reg.run != '1)) begin
      s_next.run = s_reg.run + 1'b1;
    end
    if (rise) begin
      s_next.ph = ~s_reg.ph;
      // Two pulses make one revolution; first edge only arms
      if (!s_reg.armed) begin
        s_next.armed = 1'b1;
        s_next.ph    = 1'b0;
        s_next.run   = '0;
      end else if (s_reg.ph) begin
        s_next.count = s_reg.run;
        s_next.run   = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count_out = s_reg.count;
endmodule // lfdc_tach_counter

//--- verilog/lfdc_top.sv
// Fan duty controller: register port, table scan, smoothing ramp,
// open-drain PWM and tach readout.
// Assumes temperature arrives in half-degree units, synchronous to the clock.
`timescale 1ns/100ps
module lfdc_top
  import lfdc_pkg::*;
#(
  parameter int SLOW_CYC   = SLOW_TICK_CYC,
  parameter int STEP_A_PRM = STEP_A_CYC,
  parameter int STEP_B_PRM = STEP_B_CYC,
  parameter int STEP_C_PRM = STEP_C_CYC,
  parameter int STEP_D_PRM = STEP_D_CYC
) (
  // Clock and reset
  input  wire logic          ref_clk_in,
  input  wire logic          arst_n_in,
  // Register port
  input  wire lfdc_reg_req_t reg_req_in,
  output logic [7:0]         reg_rdata_out,
  // Temperature side
  input  wire logic [8:0]    remote_temp_in,
  input  wire logic          critical_temp_output_in,
  // Fan pins
  input  wire logic          fan_tach_in,
  output logic               fan_pwm_out,
  output logic               fan_pwm_oe_out
);
  localparam logic [3:0] LAST_IDX = 4'(LUT_ENTRIES - 1);

  typedef struct packed {
    lfdc_cfg_t  cfg;
    logic [7:0] rdata;
    logic       pwm_oe;
    logic [15:0] pre;
    logic [7:0] pcnt;
    logic [7:0] duty;
    logic [23:0] step;
    logic [7:0] target;
    logic [3:0] act_idx;
    logic       act_ok;
    logic [3:0] idx;
    lfdc_scan_t ph;
    logic [3:0] d_idx;
    lfdc_scan_t d_ph;
    logic       d_ok;
    logic [9:0] cur_thr;
    logic [3:0] cand_idx;
    logic [7:0] cand_duty;
    logic       cand_ok;
  } lfdc_top_st_t;

  lfdc_top_st_t s_reg;
  lfdc_top_st_t s_next;

  logic        fine_mode;
  logic [7:0]  full_v;
  logic [7:0]  tgt;
  logic [15:0] pre_lim;
  logic        pwm_tick;
  logic [7:0]  pcnt_last;
  logic [23:0] step_lim;
  logic        step_tick;
  logic        ramp_mode;
  logic        lut_we;
  logic [4:0]  lut_waddr;
  logic [4:0]  lut_raddr;
  logic [7:0]  lut_rdata;
  logic [15:0] tach_count;
  logic [9:0]  hyst2;
  logic [9:0]  temp_hy;
  logic [9:0]  temp_w;
  logic        falling;
  logic        hit;
  logic        commit;
  logic        c_ok;
  logic [3:0]  c_idx;
  logic [7:0]  c_duty;

  // Table storage, written from the register port, read by the scan
  lfdc_lut_mem #(.WORDS(LUT_WORDS), .AW(5), .DW(8)) i_lfdc_lut_mem (
    .ref_clk_in  (ref_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (lut_we),
    .wr_addr_in  (lut_waddr),
    .wr_data_in  (reg_req_in.wdata),
    .rd_addr_in  (lut_raddr),
    .rd_data_out (lut_rdata)
  );

  // Fan speed measurement
  lfdc_tach_counter #(.TICK_CYC(TACH_TICK_CYC), .CW(16)) i_lfdc_tach_counter (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .tach_in    (fan_tach_in),
    .count_out  (tach_count)
  );

  // Mode decode and full-duty value; frequency 0 treated as 1
  always_comb begin
    fine_mode = s_reg.cfg.fine & ~s_reg.cfg.clksel
                & (s_reg.cfg.freq == FINE_FREQ);
    if (fine_mode) begin
      full_v = FULL_FINE;
    end else if (s_reg.cfg.freq == 5'h00) begin
      full_v = 8'h02;
    end else begin
      full_v = {2'b00, s_reg.cfg.freq, 1'b0};
    end
    // Clip the table target so a bad entry cannot exceed full
    tgt = (s_reg.target > full_v) ? full_v : s_reg.target;
    if (fine_mode) begin
      pre_lim = 16'(FINE_TICK_CYC - 1);
    end else if (s_reg.cfg.clksel) begin
      pre_lim = 16'(SLOW_CYC - 1);
    end else begin
      pre_lim = 16'(FAST_TICK_CYC - 1);
    end
    pwm_tick  = (s_reg.pre >= pre_lim);
    pcnt_last = full_v - 8'h01;
    unique case (s_reg.cfg.sm_int)
      2'd0: step_lim = 24'(STEP_A_PRM - 1);
      2'd1: step_lim = 24'(STEP_B_PRM - 1);
      2'd2: step_lim = 24'(STEP_C_PRM - 1);
      2'd3: step_lim = 24'(STEP_D_PRM - 1);
    endcase
    step_tick = (s_reg.step >= step_lim);
    ramp_mode = s_reg.cfg.lut_en & s_reg.cfg.sm_en & ~critical_temp_output_in;
  end

  // Table address decode for writes; scan address from state
  always_comb begin
    lut_we    = reg_req_in.wr && (reg_req_in.addr >= REG_LUT_BASE)
                && (reg_req_in.addr < 8'(REG_LUT_BASE + LUT_WORDS));
    lut_waddr = 5'(reg_req_in.addr - REG_LUT_BASE);
    lut_raddr = {s_reg.idx, (s_reg.ph == SC_DUTY)};
  end

  // Set-point comparison for the word returned this cycle
  always_comb begin
    temp_w  = {1'b0, remote_temp_in};
    hyst2   = {1'b0, s_reg.cfg.hyst, 1'b0};
    // Raising the reading stands in for lowering the point; no underflow
    temp_hy = temp_w + hyst2;
    // Entries at or below the held one use the lowered point
    falling = s_reg.act_ok && (s_reg.d_idx <= s_reg.act_idx);
    hit     = falling ? (temp_hy > s_reg.cur_thr) : (temp_w > s_reg.cur_thr);
    commit  = s_reg.d_ok && (s_reg.d_ph == SC_DUTY) && (s_reg.d_idx == LAST_IDX);
    c_ok    = s_reg.cand_ok;
    c_idx   = s_reg.cand_idx;
    c_duty  = s_reg.cand_duty;
    // Highest passed entry wins, relying on ascending programming
    if (s_reg.d_ok && (s_reg.d_ph == SC_DUTY) && hit) begin
      c_ok   = 1'b1;
      c_idx  = s_reg.d_idx;
      c_duty = lut_rdata;
    end
  end

  // Next state: registers, scan, ramp, PWM
  always_comb begin
    s_next = s_reg;
    // Register writes
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        REG_ENH_CFG: s_next.cfg.fine   = reg_req_in.wdata[FINE_BIT];
        REG_PWM_CFG: s_next.cfg.clksel = reg_req_in.wdata[CLKSEL_BIT];
        REG_DUTY:    s_next.cfg.manual = reg_req_in.wdata;
        REG_FREQ:    s_next.cfg.freq   = reg_req_in.wdata[4:0];
        REG_HYST:    s_next.cfg.hyst   = reg_req_in.wdata;
        REG_SMOOTH: begin
          s_next.cfg.sm_en    = reg_req_in.wdata[SM_EN_BIT];
          s_next.cfg.sm_int   = reg_req_in.wdata[SM_INT_LSB +: 2];
          s_next.cfg.half_res = reg_req_in.wdata[HALF_RES_BIT];
          s_next.cfg.lut_en   = reg_req_in.wdata[LUT_EN_BIT];
        end
        default: ;
      endcase
    end
    // Read data follows the address one cycle later
    unique case (reg_req_in.addr)
      REG_ENH_CFG: s_next.rdata = {3'b000, s_reg.cfg.fine, 4'h0};
      REG_TACH_LO: s_next.rdata = tach_count[7:0];
      REG_TACH_HI: s_next.rdata = tach_count[15:8];
      REG_PWM_CFG: s_next.rdata = {4'h0, s_reg.cfg.clksel, 3'b000};
      REG_DUTY:    s_next.rdata = s_reg.duty;
      REG_FREQ:    s_next.rdata = {3'b000, s_reg.cfg.freq};
      REG_HYST:    s_next.rdata = s_reg.cfg.hyst;
      REG_SMOOTH:  s_next.rdata = {3'b000, s_reg.cfg.lut_en, s_reg.cfg.half_res,
                                   s_reg.cfg.sm_int, s_reg.cfg.sm_en};
      default:     s_next.rdata = 8'h00;
    endcase
    // Scan sequencing: two words per entry, endless loop
    s_next.d_idx = s_reg.idx;
    s_next.d_ph  = s_reg.ph;
    s_next.d_ok  = 1'b1;
    if (s_reg.ph == SC_TEMP) begin
      s_next.ph = SC_DUTY;
    end else begin
      s_next.ph  = SC_TEMP;
      s_next.idx = (s_reg.idx == LAST_IDX) ? 4'h0 : s_reg.idx + 4'h1;
    end
    // Threshold in half degrees; whole-degree mode needs one half step more
    if (s_reg.d_ok && (s_reg.d_ph == SC_TEMP)) begin
      s_next.cur_thr = {1'b0, lut_rdata, 1'b0} + {9'h000, ~s_reg.cfg.half_res};
    end
    s_next.cand_ok   = c_ok;
    s_next.cand_idx  = c_idx;
    s_next.cand_duty = c_duty;
    if (commit) begin
      s_next.target  = c_ok ? c_duty : 8'h00;
      s_next.act_ok  = c_ok;
      s_next.act_idx = c_idx;
      s_next.cand_ok = 1'b0;
    end
    // Step interval timer, shared by every transition
    s_next.step = step_tick ? 24'h00_0000 : s_reg.step + 24'h00_0001;
    // Duty selection; critical temperature overrides all
    if (critical_temp_output_in) begin
      s_next.duty = full_v;
    end else if (!s_reg.cfg.lut_en) begin
      s_next.duty = s_reg.cfg.manual;
    end else if (!s_reg.cfg.sm_en) begin
      s_next.duty = tgt;
    end else if (step_tick && (s_reg.duty < tgt)) begin
      s_next.duty = s_reg.duty + 8'h01;
    end else if (step_tick && (s_reg.duty > tgt)) begin
      s_next.duty = s_reg.duty - 8'h01;
    end
    // PWM period counter; wraps early if period shrinks
    s_next.pre = pwm_tick ? 16'h0000 : s_reg.pre + 16'h0001;
    if (pwm_tick) begin
      s_next.pcnt = (s_reg.pcnt >= pcnt_last) ? 8'h00 : s_reg.pcnt + 8'h01;
    end
    // Pin released while counter below duty, pulled low otherwise
    s_next.pwm_oe = ~(s_reg.pcnt < s_reg.duty);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg            <= '0;
      s_reg.cfg.manual <= RST_MANUAL;
      s_reg.cfg.freq   <= RST_FREQ;
      s_reg.cfg.hyst   <= RST_HYST;
      s_reg.cfg.lut_en <= RST_SMOOTH[LUT_EN_BIT];
      s_reg.pwm_oe     <= 1'b1;
      s_reg.ph         <= SC_TEMP;
      s_reg.d_ph       <= SC_TEMP;
    end else begin
      s_reg <= s_next;
    end
  end

  // Open-drain: data low, enable pulls the pin
  assign fan_pwm_out    = 1'b0;
  assign fan_pwm_oe_out = s_reg.pwm_oe;
  assign reg_rdata_out  = s_reg.rdata;

  default clocking ast_cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_CRIT_FULL: assert property (
    critical_temp_output_in |=> (s_reg.duty == $past(full_v)))
    else $error("critical temperature did not force full duty");

  AST_FINE_FULL: assert property (
    (critical_temp_output_in && fine_mode) |=> (s_reg.duty == 8'hFF))
    else $error("fine mode full duty is not 0xFF");

  AST_DIRECT_STEP: assert property (
    (s_reg.cfg.lut_en && !s_reg.cfg.sm_en && !critical_temp_output_in)
      |=> (s_reg.duty == $past(tgt)))
    else $error("unsmoothed duty did not jump to target");

  AST_RAMP_UP: assert property (
    (ramp_mode && step_tick && (s_reg.duty < tgt))
      |=> (s_reg.duty == $past(s_reg.duty) + 8'h01))
    else $error("ramp up did not move one LSB");

  AST_RAMP_DOWN: assert property (
    (ramp_mode && step_tick && (s_reg.duty > tgt))
      |=> (s_reg.duty == $past(s_reg.duty) - 8'h01))
    else $error("ramp down did not move one LSB");

  AST_RAMP_HOLD: assert property (
    (ramp_mode && !step_tick) |=> $stable(s_reg.duty))
    else $error("duty moved between step intervals");

  AST_ZERO_BELOW: assert property (
    (commit && !c_ok) |=> (s_reg.target == 8'h00))
    else $error("target not zero below first set-point");

  AST_ZERO_DUTY_LOW: assert property (
    (s_reg.duty == 8'h00) |=> fan_pwm_oe_out)
    else $error("pin released at zero duty");

  AST_TACH_LOW: assert property (
    (reg_req_in.addr == REG_TACH_LO) |=> (reg_rdata_out == $past(tach_count[7:0])))
    else $error("tach low byte read mismatch");
endmodule // lfdc_top

//--- sim/lfdc_fan_model.sv
// Fan partner: pull-up on the open-drain PWM pin and a two-pulse tach.
// Assumes the bench clock; tach edges are synchronous to it.
`timescale 1ns/100ps
module lfdc_fan_model #(
  parameter int HALF_CYC = 5550
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // Fan pins
  input  wire logic pwm_oe_in,
  output logic      pwm_level_out,
  output logic      tach_out
);
  int cnt;

  // Pull-up wins whenever the device lets go of the pin
  assign pwm_level_out = pwm_oe_in ? 1'b0 : 1'b1;

  // Free-running tach, two pulses per revolution; speed ignores duty for simplicity
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt      <= 0;
      tach_out <= 1'b0;
    end else if (cnt == HALF_CYC - 1) begin
      cnt      <= 0;
      tach_out <= !tach_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // lfdc_fan_model

//--- sim/lut_fan_duty_control_bench.sv
// Self-checking bench for the fan duty controller with a fan partner.
// Assumes shortened smoothing and slow-tick parameters set below.
`timescale 1ns/100ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module lut_fan_duty_control_bench;
  import lfdc_pkg::*;
  localparam int HALF     = 5550;
  localparam int STEPS[4] = '{8, 6, 4, 2};
  logic          ref_clk;
  logic          arst_n;
  logic          crit;
  logic          tach;
  logic          pwm;
  logic          pwm_oe;
  logic          pin;
  lfdc_reg_req_t req;
  logic [7:0]    rdata;
  logic [7:0]    v;
  logic [7:0]    hi;
  logic [8:0]    temp;
  int            err_count;
  int            n_checks;

  // Device under test, short counts keep ramps brief
  lfdc_top #(.SLOW_CYC(4), .STEP_A_PRM(8), .STEP_B_PRM(6), .STEP_C_PRM(4),
    .STEP_D_PRM(2)) i_lfdc_top (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .reg_req_in(req), .reg_rdata_out(rdata),
    .remote_temp_in(temp), .critical_temp_output_in(crit), .fan_tach_in(tach),
    .fan_pwm_out(pwm), .fan_pwm_oe_out(pwm_oe));

  // Fan on the far side
  lfdc_fan_model #(.HALF_CYC(HALF)) i_lfdc_fan_model (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .pwm_oe_in(pwm_oe),
    .pwm_level_out(pin), .tach_out(tach));

  // 50 MHz clock
  initial ref_clk = 1'b0;
  always #10 ref_clk = !ref_clk;

  // Register write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 req = '{addr: a, wr: 1'b1, wdata: d};
    @(posedge ref_clk);
    #1 req.wr = 1'b0;
  endtask

  // Register read, data one edge after the address is sampled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 req.addr = a;
    @(posedge ref_clk);
    #1 d = rdata;
  endtask

  // New temperature, then two table scans with margin
  task automatic set_temp(input logic [8:0] t, input logic [7:0] e);
    @(posedge ref_clk);
    #1 temp = t;
    repeat (60) @(posedge ref_clk);
    rd(REG_DUTY, v);
    `CHK(v, e)
  endtask

  // Pin high time over exactly one PWM period
  task automatic meas(input int full, input int tick, input int d);
    int n;
    n = 0;
    repeat (full * tick) begin
      @(posedge ref_clk);
      #1 n += (pin === 1'b1) ? 1 : 0;
    end
    `CHK(n, d * tick)
  endtask

  // One smoothing interval code: gap and size of one ramp step
  task automatic t_ramp(input int code, input logic [8:0] t, input logic up);
    logic [7:0] p;
    int         n;
    wr(REG_SMOOTH, 8'h11 | 8'(code << 1));
    @(posedge ref_clk);
    #1 req.addr = REG_DUTY;
    temp = t;
    // Let the read data switch over to the duty register first
    @(posedge ref_clk);
    #1 p = rdata;
    for (int k = 0; k < 2; k++) begin
      p = rdata;
      n = 0;
      while (rdata === p && n < 300) begin
        @(posedge ref_clk);
        #1 n++;
      end
    end
    `CHK(n, STEPS[code])
    `CHK(rdata, up ? p + 8'h01 : p - 8'h01)
    repeat (300) @(posedge ref_clk);
  endtask

  // Reset state and an unmapped read
  task automatic t_reset;
    `CHK(pwm_oe, 1'b1)
    `CHK(pwm, 1'b0)
    rd(REG_DUTY, v);
    `CHK(v, 8'h00)
    rd(8'h30, v);
    `CHK(v, 8'h00)
  endtask

  // Table lookup, direct steps, half-degree and hysteresis
  task automatic t_table;
    wr(REG_ENH_CFG, 8'h10);
    wr(REG_PWM_CFG, 8'h00);
    wr(REG_FREQ, 8'h08);
    // Ascending set-points 10..120 degC, duty 0x10..0xC0
    for (int i = 0; i < 12; i++) begin
      wr(8'(REG_LUT_BASE + 2 * i), 8'(10 + 10 * i));
      wr(8'(REG_LUT_BASE + 2 * i + 1), 8'(16 * (i + 1)));
    end
    set_temp(9'd21, 8'h00);
    set_temp(9'd22, 8'h10);
    set_temp(9'd122, 8'h60);
    set_temp(9'd242, 8'hC0);
    set_temp(9'd41, 8'h20);
    set_temp(9'd38, 8'h20);
    set_temp(9'd37, 8'h10);
    wr(REG_SMOOTH, 8'h18);
    set_temp(9'd0, 8'h00);
    set_temp(9'd20, 8'h00);
    set_temp(9'd21, 8'h10);
    wr(REG_SMOOTH, 8'h10);
    set_temp(9'd42, 8'h20);
  endtask

  // Critical input overrides a settled smoothed duty
  task automatic t_crit;
    @(posedge ref_clk);
    #1 crit = 1'b1;
    req.addr = REG_DUTY;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(rdata, FULL_FINE)
    meas(255, FINE_TICK_CYC, 255);
    @(posedge ref_clk);
    #1 crit = 1'b0;
    repeat (600) @(posedge ref_clk);
  endtask

  // Fine table duty on the pin, then manual duty at the fast and slow coarse clocks
  task automatic t_pwm;
    meas(255, FINE_TICK_CYC, 8'h30);
    wr(REG_SMOOTH, 8'h00);
    wr(REG_ENH_CFG, 8'h00);
    wr(REG_DUTY, 8'h0C);
    repeat (60) @(posedge ref_clk);
    meas(16, FAST_TICK_CYC, 12);
    // Slow base clock, shortened divider in this bench
    wr(REG_PWM_CFG, 8'h08);
    repeat (60) @(posedge ref_clk);
    meas(16, 4, 12);
  endtask

  // Tach count, read-only bytes, both halves of one count
  task automatic t_tach;
    repeat (25000) @(posedge ref_clk);
    wr(REG_TACH_LO, 8'h00);
    rd(REG_TACH_LO, v);
    rd(REG_TACH_HI, hi);
    `CHK(hi, 8'h00)
    `CHK(({hi, v} >= 16'd39) && ({hi, v} <= 16'd41), 1'b1)
  endtask

  // Verdict
  task automatic results;
    $display("Checks: %0d  errors: %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog, roughly twice the expected run
  initial begin
    repeat (80000) @(posedge ref_clk);
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    err_count = 0;
    n_checks  = 0;
    arst_n    = 1'b0;
    crit      = 1'b0;
    temp      = 9'd0;
    req       = '0;
    repeat (10) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_table();
    t_ramp(0, 9'd62, 1'b1);
    t_ramp(1, 9'd82, 1'b1);
    t_ramp(2, 9'd102, 1'b1);
    t_ramp(3, 9'd61, 1'b0);
    t_crit();
    t_pwm();
    t_tach();
    results();
  end
endmodule // lut_fan_duty_control_bench
